//--- hp_host_port.sv
// Functional notes
// [R1] Accesses happen only while select is low; strobes ignored otherwise.
// [R2] Write strobe low with select latches the data bus to the location.
// [R3] Read strobe low with select drives the addressed byte onto the bus.
// [R4] Both strobes low with select counts as a write, never a read.
// [R5] Single direction-line hosts wire it to write strobe, read tied low.
// [R6] Data path is eight bits, bit 7 most significant; address nine bits.
// [R7] Pending internal interrupt pulls the open-drain interrupt pin low.
// [R8] Master reset low clears the whole port without waiting for a clock.
// [R9] The port reaches both registers and packet buffers via one address.
// [R10] Select and strobes are synchronised; each access gives one pulse.
`timescale 1ns/1ps
`include "hp_consts.svh"

module hp_host_port (
   // Clock and resets
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic master_reset_n,
   // Host pins
   input wire logic host_select_n,
   input wire logic host_write_strobe_n,
   input wire logic host_read_strobe_n,
   input wire logic [`HP_ADDR_MSB:0] host_addr_bus,
   input wire logic [`HP_DATA_MSB:0] host_data_bus_i,
   output logic [`HP_DATA_MSB:0] host_data_bus_o,
   output logic host_data_bus_oe,
   output logic host_irq_n_o,
   output logic host_irq_n_oe,
   // Core side: registers and buffers share one address space
   output logic [`HP_ADDR_MSB:0] core_addr,
   output logic [`HP_DATA_MSB:0] core_wdata,
   output logic core_wr,
   output logic core_rd,
   input wire logic [`HP_DATA_MSB:0] core_rdata,
   input wire logic core_irq
);

   // ----------------------------------------
   // Master reset
   // ----------------------------------------
   logic mrst_meta_r;
   logic mrst_n_r;

   // Clears at once, lets go two edges later, so no flop sees the pin
   // release close to a clock edge
   always_ff @(posedge ref_clk or negedge master_reset_n) // R8
   begin
      if (!master_reset_n)
      begin
         mrst_meta_r <= 1'b0;
         mrst_n_r <= 1'b0;
      end
      else
      begin
         mrst_meta_r <= 1'b1;
         mrst_n_r <= mrst_meta_r;
      end
   end

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   logic [2:0] ctl_s;
   logic [`HP_ADDR_MSB:0] addr_s;
   logic [`HP_DATA_MSB:0] data_s;

   // Address and data are synchronised too; the strobes lag them by
   // nothing, so hosts must hold them stable while the strobe is low
   hp_sync #(.W(3), .RSTV(`HP_STROBE_IDLE)) u_sync_ctl ( // R10
      .ref_clk(ref_clk),
      .reset(reset),
      .master_reset_n(mrst_n_r),
      .d({host_select_n, host_write_strobe_n, host_read_strobe_n}),
      .q(ctl_s)
   );
   hp_sync #(.W(`HP_ADDR_W + `HP_DATA_W)) u_sync_bus (
      .ref_clk(ref_clk),
      .reset(reset),
      .master_reset_n(mrst_n_r),
      .d({host_addr_bus, host_data_bus_i}),
      .q({addr_s, data_s})
   );

   // ----------------------------------------
   // Access decode
   // ----------------------------------------
   wire sel = ~ctl_s[2]; // R1
   wire wr_req = sel & ~ctl_s[1]; // R2
   wire rd_req = sel & ~ctl_s[0] & ctl_s[1]; // R3 R4

   hp_pkg::hp_state_t state_r;
   hp_pkg::hp_state_t state_nxt;
   wire in_rd = (state_r == hp_pkg::HP_ST_RD_CAP) ||
                (state_r == hp_pkg::HP_ST_RD_DRV);
   // Write wins over a read in progress, so a late write strobe aborts it
   wire start_wr = wr_req & (state_r != hp_pkg::HP_ST_WR_HOLD); // R4
   wire start_rd = rd_req & (state_r == hp_pkg::HP_ST_IDLE);
   wire cap_rd = (state_r == hp_pkg::HP_ST_RD_CAP);

   // Next state: one pass per strobe, back to idle when it ends
   always_comb
   begin
      state_nxt = state_r;
      unique case (state_r)
         hp_pkg::HP_ST_IDLE:
         begin
            if (wr_req)
               state_nxt = hp_pkg::HP_ST_WR_HOLD;
            else if (rd_req)
               state_nxt = hp_pkg::HP_ST_RD_CAP;
         end
         hp_pkg::HP_ST_RD_CAP, hp_pkg::HP_ST_RD_DRV:
         begin
            if (wr_req)
               state_nxt = hp_pkg::HP_ST_WR_HOLD;
            else if (!rd_req)
               state_nxt = hp_pkg::HP_ST_IDLE;
            else
               state_nxt = hp_pkg::HP_ST_RD_DRV;
         end
         hp_pkg::HP_ST_WR_HOLD:
         begin
            if (!wr_req)
               state_nxt = hp_pkg::HP_ST_IDLE;
         end
      endcase
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   // Sequencer and strobes to the core
   always_ff @(posedge ref_clk or negedge mrst_n_r) // R8
   begin
      if (!mrst_n_r)
      begin
         state_r <= hp_pkg::HP_ST_IDLE;
         core_wr <= 1'b0;
         core_rd <= 1'b0;
      end
      else if (reset)
      begin
         state_r <= hp_pkg::HP_ST_IDLE;
         core_wr <= 1'b0;
         core_rd <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         core_wr <= start_wr; // R2 R10
         core_rd <= start_rd; // R3 R10
      end
   end

   // Address and write data to the core, loaded at access start
   always_ff @(posedge ref_clk or negedge mrst_n_r)
   begin
      if (!mrst_n_r)
      begin
         core_addr <= `HP_ADDR_RST;
         core_wdata <= `HP_DATA_RST;
      end
      else if (reset)
      begin
         core_addr <= `HP_ADDR_RST;
         core_wdata <= `HP_DATA_RST;
      end
      else if (start_wr || start_rd)
      begin
         core_addr <= addr_s; // R6 R9
         core_wdata <= data_s; // R2
      end
   end

   // Bus drive: data captured in the same cycle as the read pulse
   always_ff @(posedge ref_clk or negedge mrst_n_r)
   begin
      if (!mrst_n_r)
      begin
         host_data_bus_o <= `HP_DATA_RST;
         host_data_bus_oe <= 1'b0;
      end
      else if (reset)
      begin
         host_data_bus_o <= `HP_DATA_RST;
         host_data_bus_oe <= 1'b0;
      end
      else
      begin
         if (cap_rd)
            host_data_bus_o <= core_rdata; // R3
         host_data_bus_oe <= (state_nxt == hp_pkg::HP_ST_RD_DRV); // R3
      end
   end

   // Open drain interrupt: only ever drives low
   always_ff @(posedge ref_clk or negedge mrst_n_r)
   begin
      if (!mrst_n_r)
      begin
         host_irq_n_o <= 1'b0;
         host_irq_n_oe <= 1'b0;
      end
      else if (reset)
      begin
         host_irq_n_o <= 1'b0;
         host_irq_n_oe <= 1'b0;
      end
      else
      begin
         host_irq_n_o <= 1'b0;
         host_irq_n_oe <= core_irq; // R7
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   property p_sel_gate;
      @(posedge ref_clk) disable iff (reset || !master_reset_n)
      (core_wr || core_rd) |-> $past(sel);
   endproperty
   a_sel_gate: assert property (p_sel_gate) // R1
      else $error("core access without host select");

   property p_write_latch;
      @(posedge ref_clk) disable iff (reset || !master_reset_n)
      (state_r == hp_pkg::HP_ST_IDLE && wr_req) |=>
         (core_wr && core_wdata == $past(data_s) &&
          state_r == hp_pkg::HP_ST_WR_HOLD);
   endproperty
   a_write_latch: assert property (p_write_latch) // R2
      else $error("write not latched from the data bus");

   property p_read_drive;
      @(posedge ref_clk) disable iff (reset || !master_reset_n)
      (state_r == hp_pkg::HP_ST_IDLE && rd_req) ##1 (rd_req && !wr_req)
         |=> (host_data_bus_oe && host_data_bus_o == $past(core_rdata));
   endproperty
   a_read_drive: assert property (p_read_drive) // R3
      else $error("read byte not driven on the data bus");

   property p_both_low_write;
      @(posedge ref_clk) disable iff (reset || !master_reset_n)
      wr_req |=> (!core_rd && !host_data_bus_oe);
   endproperty
   a_both_low_write: assert property (p_both_low_write) // R4
      else $error("read issued while write strobe low");

   property p_addr_pass;
      @(posedge ref_clk) disable iff (reset || !master_reset_n)
      (start_wr || start_rd) |=> core_addr == $past(addr_s);
   endproperty
   a_addr_pass: assert property (p_addr_pass) // R6
      else $error("address not passed to the core");

   property p_irq_pin;
      @(posedge ref_clk) disable iff (reset || !mrst_n_r)
      mrst_n_r |=> (host_irq_n_oe == $past(core_irq) && !host_irq_n_o);
   endproperty
   a_irq_pin: assert property (p_irq_pin) // R7
      else $error("interrupt pin does not follow pending interrupt");

   property p_master_reset;
      @(posedge ref_clk) disable iff (reset)
      !master_reset_n |-> (!host_data_bus_oe && !host_irq_n_oe &&
                           !core_wr && state_r == hp_pkg::HP_ST_IDLE);
   endproperty
   a_master_reset: assert property (p_master_reset) // R8
      else $error("master reset did not clear the port");

   property p_one_pulse;
      @(posedge ref_clk) disable iff (reset || !master_reset_n)
      (core_wr || core_rd) |=> (!core_wr && !core_rd);
   endproperty
   a_one_pulse: assert property (p_one_pulse) // R10
      else $error("access produced more than one core pulse");

   property p_hold_idle;
      @(posedge ref_clk) disable iff (reset || !master_reset_n)
      (state_r == hp_pkg::HP_ST_WR_HOLD && !wr_req) |=>
         (state_r == hp_pkg::HP_ST_IDLE && !in_rd);
   endproperty
   a_hold_idle: assert property (p_hold_idle) // R10
      else $error("port did not return to idle after write");

endmodule

//--- hp_consts.svh
`ifndef HP_CONSTS_SVH
`define HP_CONSTS_SVH

// ----------------------------------------
// Host port widths
// ----------------------------------------
`define HP_DATA_W 8
`define HP_ADDR_W 9
`define HP_DATA_MSB 7
`define HP_ADDR_MSB 8

// ----------------------------------------
// Reset values
// ----------------------------------------
`define HP_STROBE_IDLE 3'h7
`define HP_DATA_RST 8'h00
`define HP_ADDR_RST 9'h000

// ----------------------------------------
// Timing: depth of the input synchroniser
// ----------------------------------------
`define HP_SYNC_STAGES 2

`endif

//--- hp_pkg.sv
package hp_pkg;

   // Access sequencer, Gray coded along idle -> capture -> drive
   typedef enum logic [1:0]
   {
      HP_ST_IDLE = 2'b00,
      HP_ST_RD_CAP = 2'b01,
      HP_ST_RD_DRV = 2'b11,
      HP_ST_WR_HOLD = 2'b10
   } hp_state_t;

endpackage

//--- hp_sync.sv
`timescale 1ns/1ps
`include "hp_consts.svh"

module hp_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RSTV = '0
) (
   // Clock and resets
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic master_reset_n,
   // Asynchronous in, synchronous out
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   // ----------------------------------------
   // Two flops per bit; the first is read by the second only
   // ----------------------------------------
   genvar i;
   generate
      for (i = 0; i < W; i++)
      begin : g_bit
         logic meta_r;
         logic sync_r;
         // Async clear takes constants only
         always_ff @(posedge ref_clk or negedge master_reset_n)
         begin
            if (!master_reset_n)
            begin
               meta_r <= RSTV[i];
               sync_r <= RSTV[i];
            end
            else if (reset)
            begin
               meta_r <= RSTV[i];
               sync_r <= RSTV[i];
            end
            else
            begin
               meta_r <= d[i];
               sync_r <= meta_r;
            end
         end
         assign q[i] = sync_r;
      end
   endgenerate

endmodule

//--- hp_host_model.sv
`timescale 1ns/1ps
`include "hp_consts.svh"

module hp_host_model (
   // Clock
   input wire logic ref_clk,
   // Device side of the data pins
   input wire logic [`HP_DATA_MSB:0] dev_data,
   input wire logic dev_oe,
   // Host pins
   output logic sel_n,
   output logic wr_n,
   output logic rd_n,
   output logic [`HP_ADDR_MSB:0] addr,
   output logic [`HP_DATA_MSB:0] bus_level
);
   // ----------------------------------------
   // Data pin level
   // ----------------------------------------
   logic host_oe = 1'b0;
   logic [`HP_DATA_MSB:0] host_d = 8'h00;
   logic [`HP_DATA_MSB:0] last_r = 8'h00;

   // No pull on the data pins, so a released bus shows the inverse value
   assign bus_level = dev_oe ? dev_data : (host_oe ? host_d : ~last_r);

   // Remember the last driven level
   always @(posedge ref_clk)
   begin
      if (dev_oe | host_oe)
         last_r <= bus_level;
   end

   initial
   begin
      sel_n = 1'b1;
      wr_n = 1'b1;
      rd_n = 1'b1;
      addr = 9'h000;
   end

   // ----------------------------------------
   // One host access, pins moved at falling edges
   // ----------------------------------------
   // Fixed hold: this bus has no ready, the host times the strobe itself
   task automatic access(input logic do_wr, input logic do_rd,
      input logic sel, input logic [`HP_ADDR_MSB:0] a,
      input logic [`HP_DATA_MSB:0] d, output logic [`HP_DATA_MSB:0] q);
      @(negedge ref_clk);
      addr = a;
      host_d = d;
      host_oe = do_wr;
      sel_n = ~sel;
      wr_n = ~do_wr;
      rd_n = ~do_rd;
      repeat (8) @(negedge ref_clk);
      q = bus_level;
      wr_n = 1'b1;
      rd_n = 1'b1;
      host_oe = 1'b0;
      @(negedge ref_clk);
      sel_n = 1'b1;
      // Strobes must idle long enough for the synchroniser to see it
      repeat (4) @(negedge ref_clk);
   endtask
endmodule

//--- hp_host_port_test.sv
`timescale 1ns/1ps
`include "hp_consts.svh"

module hp_host_port_test;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic master_reset_n = 1'b1;
   logic core_irq = 1'b0;
   logic sel_n, wr_n, rd_n, d_oe, irq_o, irq_oe, core_wr, core_rd;
   logic [`HP_ADDR_MSB:0] addr, core_addr;
   logic [`HP_DATA_MSB:0] bus, d_o, core_wdata, core_rdata, q;
   logic [`HP_DATA_MSB:0] mem [512];
   int failures = 0;
   int n_checks = 0;
   int n_wr = 0;
   int n_rd = 0;
   int cycles = 0;
   int w0, r0;
   logic [`HP_ADDR_MSB:0] row_addr [4] = '{9'h000, 9'h1ff, 9'h0aa, 9'h155};
   logic [`HP_DATA_MSB:0] row_data [4] = '{8'h80, 8'h01, 8'h5a, 8'ha5};

   // ----------------------------------------
   // Clock, core memory and pulse counters
   // ----------------------------------------
   initial
   begin
      forever #4 ref_clk = ~ref_clk;
   end

   // Core answer follows the held address, valid well before it is sampled
   assign core_rdata = mem[core_addr];

   always @(posedge ref_clk)
   begin
      cycles++;
      if (core_wr === 1'b1)
      begin
         n_wr++;
         mem[core_addr] <= core_wdata;
      end
      if (core_rd === 1'b1)
         n_rd++;
      if (cycles == 3000)
      begin
         failures++;
         final_report();
      end
   end

   hp_host_port i_hp_host_port (.ref_clk(ref_clk), .reset(reset),
      .master_reset_n(master_reset_n), .host_select_n(sel_n),
      .host_write_strobe_n(wr_n), .host_read_strobe_n(rd_n),
      .host_addr_bus(addr), .host_data_bus_i(bus),
      .host_data_bus_o(d_o), .host_data_bus_oe(d_oe),
      .host_irq_n_o(irq_o), .host_irq_n_oe(irq_oe), .core_addr(core_addr),
      .core_wdata(core_wdata), .core_wr(core_wr), .core_rd(core_rd),
      .core_rdata(core_rdata), .core_irq(core_irq));

   hp_host_model i_hp_host_model (.ref_clk(ref_clk), .dev_data(d_o),
      .dev_oe(d_oe), .sel_n(sel_n), .wr_n(wr_n), .rd_n(rd_n),
      .addr(addr), .bus_level(bus));

   // ----------------------------------------
   // Checking and closing
   // ----------------------------------------
   task automatic chk(input bit ok, input string msg);
      n_checks++;
      if (!ok)
      begin
         failures++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask

   task automatic final_report();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      repeat (5) @(negedge ref_clk);
      reset = 1'b0;
      chk(d_oe === 1'b0 && irq_oe === 1'b0 && core_wr === 1'b0, "reset out");
      // Table rows: write a byte, read it back through the pins
      for (int i = 0; i < 4; i++)
      begin
         w0 = n_wr;
         r0 = n_rd;
         i_hp_host_model.access(1, 0, 1, row_addr[i], row_data[i], q);
         chk(n_wr === w0 + 1, "one write pulse");
         chk(mem[row_addr[i]] === row_data[i], "write data");
         i_hp_host_model.access(0, 1, 1, row_addr[i], 8'h00, q);
         chk(q === row_data[i], "read data");
         chk(d_oe === 1'b0, "bus released after read");
         chk(n_rd === r0 + 1 && n_wr === w0 + 1, "one read pulse");
      end
      // Strobes with select high do nothing
      w0 = n_wr;
      r0 = n_rd;
      i_hp_host_model.access(1, 0, 0, 9'h000, 8'h3c, q);
      i_hp_host_model.access(0, 1, 0, 9'h000, 8'h00, q);
      chk(n_wr === w0 && n_rd === r0, "deselected access");
      chk(mem[9'h000] === 8'h80, "deselected write");
      // Both strobes low is a write, as a single direction line host uses
      i_hp_host_model.access(1, 1, 1, 9'h1ff, 8'hc3, q);
      chk(n_wr === w0 + 1 && n_rd === r0, "both strobes");
      chk(mem[9'h1ff] === 8'hc3, "both strobes data");
      // Direction line high with read held low reads the byte back
      i_hp_host_model.access(0, 1, 1, 9'h1ff, 8'h00, q);
      chk(q === 8'hc3 && n_rd === r0 + 1, "direction line read");
      // Interrupt pin pulled low while the core requests
      @(negedge ref_clk);
      core_irq = 1'b1;
      repeat (2) @(negedge ref_clk);
      chk(irq_oe === 1'b1 && irq_o === 1'b0, "irq low");
      // Synchronous reset mid-run drops the pin, which returns after it
      reset = 1'b1;
      @(negedge ref_clk);
      chk(irq_oe === 1'b0 && core_addr === 9'h000, "sync reset");
      reset = 1'b0;
      repeat (2) @(negedge ref_clk);
      chk(irq_oe === 1'b1 && irq_o === 1'b0, "irq after reset");
      // Master reset clears without any clock edge
      #2 master_reset_n = 1'b0;
      #1 chk(irq_oe === 1'b0 && core_addr === 9'h000, "async reset");
      @(negedge ref_clk);
      core_irq = 1'b0;
      master_reset_n = 1'b1;
      repeat (2) @(negedge ref_clk);
      chk(irq_oe === 1'b0, "irq released");
      final_report();
   end
endmodule
